// ---- dv/modbus_master_model.sv ----
// master model for the register port: one register word per call
// assumes one bench process calls its tasks, clock from the bench
`timescale 1ns/1ps

module modbus_master_model
   import commit_alarm_pkg::*;
(
   input wire logic clk_i,
   output logic valid_o,
   output logic write_o,
   output logic bcast_o,
   output logic first_o,
   output logic last_o,
   output logic [15:0] addr_o,
   output logic [15:0] data_o
);
   // endurance budget; the bench issues only one store
   int nv_commits = 0;

   initial begin
      {valid_o, write_o, bcast_o, first_o, last_o} = 5'h00;
      addr_o = 16'h0000;
      data_o = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // word launched after an edge, taken at the next one
   task automatic word(input logic wr, input logic bc, input logic fi,
         input logic la, input logic [15:0] ad, input logic [15:0] da);
      @(posedge clk_i);
      valid_o <= 1'b1;
      write_o <= wr;
      bcast_o <= bc;
      first_o <= fi;
      last_o <= la;
      addr_o <= ad;
      data_o <= da;
      if (wr && ad == COMMIT_NV_ADDR && da == COMMIT_TRIGGER_VALUE) begin
         nv_commits++;
      end
   endtask : word

   // released address and data lines flip so a stale word never looks fresh
   task automatic idle();
      @(posedge clk_i);
      valid_o <= 1'b0;
      addr_o <= ~addr_o;
      data_o <= ~data_o;
   endtask : idle
endmodule : modbus_master_model

// ---- dv/tb_top.sv ----
// self-checking bench for the commit and alarm register block
// assumes the master model drives the register port
`timescale 1ns/1ps

module tb_top
   import commit_alarm_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic mode = 1'b0;
   logic [5:0] ext = 6'h00;
   logic tx_err = 1'b0;
   logic fan = 1'b0;
   logic cap = 1'b0;
   logic rv, rw, rb, rf, rl, rsp_valid, rsp_error, nv_store, nv_wear;
   logic [15:0] ra, rd, rsp_data, alarm, ref_o;
   logic [7:0] rsp_code;
   logic [63:0] act, nv;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;

   always #50 ref_clk = ~ref_clk;

   modbus_master_model m (.clk_i(ref_clk), .valid_o(rv), .write_o(rw),
      .bcast_o(rb), .first_o(rf), .last_o(rl), .addr_o(ra), .data_o(rd));

   parameter_commit_alarm_regs uut (.REF_CLK_I(ref_clk), .RST_I(rst),
      .REQ_VALID_I(rv), .REQ_WRITE_I(rw), .REQ_BCAST_I(rb),
      .REQ_FIRST_I(rf), .REQ_LAST_I(rl), .REQ_ADDR_I(ra), .REQ_DATA_I(rd),
      .COMMIT_MODE_SELECT_I(mode), .EXT_FAULT_I(ext),
      .LINK_TX_ERROR_I(tx_err), .FAN_SERVICE_DUE_I(fan),
      .CAPACITOR_SERVICE_DUE_I(cap), .RSP_VALID_O(rsp_valid),
      .RSP_ERROR_O(rsp_error), .RSP_CODE_O(rsp_code),
      .RSP_DATA_O(rsp_data), .ALARM_CODE_O(alarm), .REFERENCE_O(ref_o),
      .NV_STORE_O(nv_store), .NV_WEAR_LIMIT_O(nv_wear),
      .ACTIVE_PARAMS_O(act), .NV_PARAMS_O(nv));

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   // tests run about 90 cycles; far above that means a hang
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic chk_val(input logic [15:0] g, input logic [15:0] e,
         input string s);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, g, e);
      end
   endtask : chk_val

   task automatic chk_bit(input logic g, input logic e, input string s);
      chk_val({15'h0000, g}, {15'h0000, e}, s);
   endtask : chk_bit

   // answer stands only in the cycle after the taking edge, no slack
   task automatic get_rsp(input logic [7:0] c, input logic [15:0] d);
      #1;
      chk_bit(rsp_valid, 1'b1, "answer");
      chk_bit(rsp_error, c != ERR_NONE, "error flag");
      chk_val({8'h00, rsp_code}, {8'h00, c}, "code");
      chk_val(rsp_data, d, "read data");
   endtask : get_rsp

   task automatic wr1(input logic [15:0] a, input logic [15:0] d);
      m.word(1'b1, 1'b0, 1'b1, 1'b1, a, d);
      m.idle();
   endtask : wr1

   task automatic rd1(input logic [15:0] a);
      m.word(1'b0, 1'b0, 1'b1, 1'b1, a, 16'h0000);
      m.idle();
   endtask : rd1

   // alarm inputs change on an edge; alarm register follows one edge later
   task automatic rd_alarm(input logic [5:0] e, input logic [2:0] tfc,
         input logic [15:0] x);
      @(posedge ref_clk);
      ext <= e;
      {tx_err, fan, cap} <= tfc;
      @(posedge ref_clk);
      rd1(ALARM_ADDR);
      get_rsp(ERR_NONE, x);
      chk_val(alarm, x, "alarm output");
   endtask : rd_alarm

   ////////////////////////////////////////////////////////////////////////
   task automatic t_alarm();
      for (int i = 0; i < EXT_FAULT_COUNT; i++) begin
         rd_alarm(6'h01 << i, 3'b000, ALARM_EXT_FAULT_FIRST + 16'(i));
      end
      rd_alarm(6'h3f, 3'b100, ALARM_EXT_FAULT_FIRST);
      rd_alarm(6'h00, 3'b100, ALARM_LINK_TX_ERR);
      rd_alarm(6'h00, 3'b011, ALARM_FAN_SERVICE);
      rd_alarm(6'h00, 3'b001, ALARM_CAP_SERVICE);
      rd_alarm(6'h00, 3'b000, ALARM_NONE);
      $display("test alarm done");
   endtask : t_alarm

   // odd member written: a value below its even partner would be dropped
   task automatic t_commit();
      wr1(PARAM_BASE_ADDR + 16'h0001, 16'h1234);
      get_rsp(ERR_NONE, 16'h0000);
      chk_val(act[31:16], 16'h0000, "still pending");
      wr1(COMMIT_RAM_ADDR, 16'h0000);
      get_rsp(ERR_NONE, 16'h0000);
      chk_val(act[31:16], 16'h1234, "ram commit");
      chk_val(nv[31:16], 16'h0000, "nv untouched");
      wr1(COMMIT_NV_ADDR, 16'h0001);
      get_rsp(ERR_DATA_SETTING, 16'h0000);
      chk_bit(nv_store, 1'b0, "no store");
      wr1(COMMIT_NV_ADDR, 16'h0000);
      get_rsp(ERR_NONE, 16'h0000);
      chk_bit(nv_store, 1'b1, "store pulse");
      chk_val(nv[31:16], 16'h1234, "nv image");
      chk_val(act[31:16], 16'h1234, "active kept");
      chk_bit(m.nv_commits == 1, 1'b1, "store budget");
      $display("test commit done");
   endtask : t_commit

   task automatic t_refused();
      logic [15:0] a [3];
      a = '{COMMIT_NV_ADDR, COMMIT_RAM_ADDR, 16'h0200};
      for (int i = 0; i < 3; i++) begin
         rd1(a[i]);
         get_rsp(ERR_REG_NUMBER, 16'h0000);
      end
      wr1(ALARM_ADDR, 16'h0001);
      get_rsp(ERR_WRITE_MODE, 16'h0000);
      $display("test refused done");
   endtask : t_refused

   task automatic t_reference();
      wr1(REF_ADDR, 16'h00a5);
      get_rsp(ERR_NONE, 16'h0000);
      chk_val(ref_o, 16'h00a5, "reference");
      m.word(1'b1, 1'b1, 1'b1, 1'b1, REF_ADDR, 16'h005a);
      m.idle();
      #1;
      chk_bit(rsp_valid, 1'b0, "broadcast silent");
      chk_val(ref_o, 16'h005a, "broadcast ref");
      $display("test reference done");
   endtask : t_reference

   // deferred: bad value dropped silently, related check uses pending
   task automatic t_deferred();
      m.word(1'b1, 1'b0, 1'b1, 1'b0, PARAM_BASE_ADDR + 16'h0001, 16'h2000);
      m.word(1'b1, 1'b0, 1'b0, 1'b0, PARAM_BASE_ADDR, 16'h0010);
      m.word(1'b1, 1'b0, 1'b0, 1'b1, PARAM_BASE_ADDR + 16'h0003, 16'h9000);
      m.idle();
      get_rsp(ERR_NONE, 16'h0000);
      chk_val(act[31:16], 16'h1234, "multi pending");
      wr1(PARAM_BASE_ADDR + 16'h0001, 16'h8000);
      get_rsp(ERR_NONE, 16'h0000);
      wr1(PARAM_BASE_ADDR + 16'h0002, 16'h0100);
      get_rsp(ERR_NONE, 16'h0000);
      wr1(COMMIT_RAM_ADDR, 16'h0000);
      get_rsp(ERR_NONE, 16'h0000);
      chk_val(act[15:0], 16'h0010, "kept value");
      chk_val(act[31:16], 16'h2000, "kept value");
      chk_val(act[47:32], 16'h0000, "related drop");
      chk_val(act[63:48], 16'h0000, "partner untouched");
      $display("test deferred done");
   endtask : t_deferred

   task automatic t_immediate();
      @(posedge ref_clk);
      mode <= MODE_IMMEDIATE;
      wr1(PARAM_BASE_ADDR + 16'h0002, 16'h0050);
      get_rsp(ERR_NONE, 16'h0000);
      chk_val(act[47:32], 16'h0050, "applied at once");
      chk_val(act[63:48], 16'h0050, "partner follows");
      wr1(PARAM_BASE_ADDR + 16'h0003, 16'h8000);
      get_rsp(ERR_DATA_SETTING, 16'h0000);
      chk_val(act[63:48], 16'h0050, "limit refused");
      m.word(1'b1, 1'b0, 1'b1, 1'b0, PARAM_BASE_ADDR, 16'h0011);
      m.word(1'b1, 1'b0, 1'b0, 1'b1, PARAM_BASE_ADDR + 16'h0001, 16'h9000);
      m.idle();
      get_rsp(ERR_DATA_SETTING, 16'h0000);
      chk_val(act[15:0], 16'h0010, "all discarded");
      m.word(1'b1, 1'b0, 1'b1, 1'b0, PARAM_BASE_ADDR, 16'h0020);
      m.word(1'b1, 1'b0, 1'b0, 1'b1, PARAM_BASE_ADDR + 16'h0001, 16'h0030);
      m.idle();
      get_rsp(ERR_NONE, 16'h0000);
      chk_val(act[15:0], 16'h0020, "both applied");
      chk_val(act[31:16], 16'h0030, "both applied");
      $display("test immediate done");
   endtask : t_immediate

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      chk_val(act[15:0], PARAM_RESET_VALUE, "reset param");
      chk_bit(nv_wear, 1'b0, "reset wear");
      t_alarm();
      t_commit();
      t_refused();
      t_reference();
      t_deferred();
      t_immediate();
      report_and_stop();
   end
endmodule : tb_top

// ---- inc/commit_alarm_pkg.sv ----
// constants for the parameter commit and alarm register block
// assumes a frame parser upstream that hands over one register word at a time
package commit_alarm_pkg;

   // register addresses
   localparam logic [15:0] REF_ADDR = 16'h0001;
   localparam logic [15:0] ALARM_ADDR = 16'h007f;
   localparam logic [15:0] PARAM_BASE_ADDR = 16'h0100;
   localparam logic [15:0] COMMIT_NV_ADDR = 16'h0900;
   localparam logic [15:0] COMMIT_RAM_ADDR = 16'h0910;

   // value that fires a commit
   localparam logic [15:0] COMMIT_TRIGGER_VALUE = 16'h0000;

   // alarm codes
   localparam logic [15:0] ALARM_NONE = 16'h0000;
   localparam logic [15:0] ALARM_EXT_FAULT_FIRST = 16'h0009;
   localparam logic [15:0] ALARM_EXT_FAULT_LAST = 16'h000e;
   localparam logic [15:0] ALARM_LINK_TX_ERR = 16'h0016;
   localparam logic [15:0] ALARM_LINK_TX_ERR_ALT = 16'h001d;
   localparam logic [15:0] ALARM_FAN_SERVICE = 16'h0035;
   localparam logic [15:0] ALARM_CAP_SERVICE = 16'h0036;
   localparam int EXT_FAULT_COUNT = 6;

   // answer codes
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_REG_NUMBER = 8'h02;
   localparam logic [7:0] ERR_DATA_SETTING = 8'h21;
   localparam logic [7:0] ERR_WRITE_MODE = 8'h22;

   // commit mode setting
   localparam logic MODE_DEFERRED = 1'b0;
   localparam logic MODE_IMMEDIATE = 1'b1;

   // parameter limits and reset values
   localparam logic [15:0] PARAM_MIN_VALUE = 16'h0000;
   localparam logic [15:0] PARAM_MAX_VALUE = 16'h7fff;
   localparam logic [15:0] PARAM_RESET_VALUE = 16'h0000;
   localparam logic [15:0] REF_RESET_VALUE = 16'h0000;

   // non-volatile store endurance
   localparam int NV_ENDURANCE_CYCLES = 100000;
   localparam int NV_COUNT_WIDTH = 17;

endpackage : commit_alarm_pkg

// ---- verilog/parameter_commit_alarm_regs.sv ----
// register side of a drive's serial slave: alarm code, commit registers,
// deferred or immediate parameter activation with range checks
// assumes one decoded register word per REQ_VALID_I, message framed by
// REQ_FIRST_I/REQ_LAST_I, all inputs synchronous to REF_CLK_I
`timescale 1ns/1ps

module parameter_commit_alarm_regs
   import commit_alarm_pkg::*;
#(
   parameter int NUM_PARAMS = 4,
   parameter bit USE_ALT_TX_CODE = 1'b0
) (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic REQ_VALID_I,
   input wire logic REQ_WRITE_I,
   input wire logic REQ_BCAST_I,
   input wire logic REQ_FIRST_I,
   input wire logic REQ_LAST_I,
   input wire logic [15:0] REQ_ADDR_I,
   input wire logic [15:0] REQ_DATA_I,
   input wire logic COMMIT_MODE_SELECT_I,
   input wire logic [EXT_FAULT_COUNT-1:0] EXT_FAULT_I,
   input wire logic LINK_TX_ERROR_I,
   input wire logic FAN_SERVICE_DUE_I,
   input wire logic CAPACITOR_SERVICE_DUE_I,
   output logic RSP_VALID_O,
   output logic RSP_ERROR_O,
   output logic [7:0] RSP_CODE_O,
   output logic [15:0] RSP_DATA_O,
   output logic [15:0] ALARM_CODE_O,
   output logic [15:0] REFERENCE_O,
   output logic NV_STORE_O,
   output logic NV_WEAR_LIMIT_O,
   output logic [16*NUM_PARAMS-1:0] ACTIVE_PARAMS_O,
   output logic [16*NUM_PARAMS-1:0] NV_PARAMS_O
);

   localparam int IW = (NUM_PARAMS > 1) ? $clog2(NUM_PARAMS) : 1;

   ////////////////////////////////////////////////////////////////////////
   // state

   logic [15:0] active_reg [NUM_PARAMS];
   logic [15:0] pending_reg [NUM_PARAMS];
   logic [15:0] trial_reg [NUM_PARAMS];
   logic [15:0] nv_reg [NUM_PARAMS];
   logic [15:0] trial_next [NUM_PARAMS];
   logic [15:0] alarm_reg;
   logic [15:0] reference_reg;
   logic [7:0] msg_code_reg;
   logic rsp_valid_reg;
   logic rsp_error_reg;
   logic [7:0] rsp_code_reg;
   logic [15:0] rsp_data_reg;
   logic nv_store_reg;
   logic [NV_COUNT_WIDTH-1:0] nv_count_reg;
   logic nv_wear_reg;
   logic [16*NUM_PARAMS-1:0] pending_flat;

   ////////////////////////////////////////////////////////////////////////
   // alarm encoding

   // lowest terminal wins so the first fault in the chain is reported
   function automatic logic [15:0] alarm_encode(
      input logic [EXT_FAULT_COUNT-1:0] ext,
      input logic tx_err,
      input logic fan,
      input logic cap
   );
      logic [15:0] code;
      code = ALARM_NONE;
      if (cap) begin
         code = ALARM_CAP_SERVICE;
      end
      if (fan) begin
         code = ALARM_FAN_SERVICE;
      end
      if (tx_err) begin
         code = USE_ALT_TX_CODE ? ALARM_LINK_TX_ERR_ALT :
                ALARM_LINK_TX_ERR;
      end
      for (int i = EXT_FAULT_COUNT - 1; i >= 0; i--) begin
         if (ext[i]) begin
            code = ALARM_EXT_FAULT_FIRST + 16'(i);
         end
      end
      return code;
   endfunction : alarm_encode

   wire logic [15:0] alarm_next = alarm_encode(EXT_FAULT_I, LINK_TX_ERROR_I,
      FAN_SERVICE_DUE_I, CAPACITOR_SERVICE_DUE_I);

   ////////////////////////////////////////////////////////////////////////
   // address decode

   wire logic [15:0] addr_off = REQ_ADDR_I - PARAM_BASE_ADDR;
   wire logic hit_alarm = (REQ_ADDR_I == ALARM_ADDR);
   wire logic hit_ref = (REQ_ADDR_I == REF_ADDR);
   wire logic hit_nv = (REQ_ADDR_I == COMMIT_NV_ADDR);
   wire logic hit_ram = (REQ_ADDR_I == COMMIT_RAM_ADDR);
   wire logic hit_param = (REQ_ADDR_I >= PARAM_BASE_ADDR) &&
                          (addr_off < 16'(NUM_PARAMS));
   wire logic [IW-1:0] idx = addr_off[IW-1:0];
   // parameters are paired low/high; the partner must stay on its side
   wire logic [IW-1:0] partner = idx ^ IW'(1);
   wire logic has_partner = (32'(partner) < NUM_PARAMS);
   wire logic mode_imm = (COMMIT_MODE_SELECT_I == MODE_IMMEDIATE);

   wire logic wr = REQ_VALID_I && REQ_WRITE_I;
   wire logic rd = REQ_VALID_I && !REQ_WRITE_I;
   wire logic trigger = (REQ_DATA_I == COMMIT_TRIGGER_VALUE);
   wire logic commit_nv = wr && hit_nv && trigger && !REQ_BCAST_I;
   wire logic commit_ram = wr && hit_ram && trigger && !REQ_BCAST_I;
   wire logic ref_write = wr && hit_ref;

   ////////////////////////////////////////////////////////////////////////
   // range checks

   wire logic in_limits = (REQ_DATA_I >= PARAM_MIN_VALUE) &&
                          (REQ_DATA_I <= PARAM_MAX_VALUE);
   wire logic [15:0] pend_partner = pending_reg[partner];
   // low member must not exceed high member and the other way round
   wire logic related_ok = !has_partner ||
      (idx[0] ? (REQ_DATA_I >= pend_partner) :
                (REQ_DATA_I <= pend_partner));
   wire logic param_ok = in_limits && (mode_imm || related_ok);
   wire logic param_wr = wr && hit_param && !REQ_BCAST_I;
   wire logic defer_store = param_wr && !mode_imm && param_ok;

   ////////////////////////////////////////////////////////////////////////
   // per-word answer code

   wire logic [7:0] read_code =
      (hit_alarm || hit_ref || hit_param) ? ERR_NONE :
      ERR_REG_NUMBER;
   wire logic [7:0] write_code =
      hit_ref ? ERR_NONE :
      REQ_BCAST_I ? ERR_REG_NUMBER :
      (hit_nv || hit_ram) ? (trigger ? ERR_NONE : ERR_DATA_SETTING) :
      hit_alarm ? ERR_WRITE_MODE :
      hit_param ? ((param_ok || !mode_imm) ? ERR_NONE :
                   ERR_DATA_SETTING) :
      ERR_REG_NUMBER;
   wire logic [7:0] word_code = REQ_WRITE_I ? write_code : read_code;
   wire logic carry_err = !REQ_FIRST_I && (msg_code_reg != ERR_NONE);
   wire logic [7:0] code_now = carry_err ? msg_code_reg : word_code;
   wire logic imm_commit = wr && mode_imm && REQ_LAST_I &&
                           (code_now == ERR_NONE);
   wire logic answer = REQ_VALID_I && REQ_LAST_I && !REQ_BCAST_I;
   wire logic [15:0] read_value =
      hit_alarm ? alarm_reg :
      hit_ref ? reference_reg :
      hit_param ? active_reg[idx] :
      16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // trial copy for immediate mode: a message builds on the active set

   always_comb begin
      for (int i = 0; i < NUM_PARAMS; i++) begin
         trial_next[i] = REQ_FIRST_I ? active_reg[i] : trial_reg[i];
      end
      if (param_wr && mode_imm && param_ok) begin
         trial_next[idx] = REQ_DATA_I;
         if (has_partner && (idx[0] ? (REQ_DATA_I < trial_next[partner]) :
                             (REQ_DATA_I > trial_next[partner]))) begin
            trial_next[partner] = REQ_DATA_I;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // parameter storage

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         for (int i = 0; i < NUM_PARAMS; i++) begin
            active_reg[i] <= PARAM_RESET_VALUE;
            pending_reg[i] <= PARAM_RESET_VALUE;
            trial_reg[i] <= PARAM_RESET_VALUE;
            nv_reg[i] <= PARAM_RESET_VALUE;
         end
      end else begin
         if (REQ_VALID_I) begin
            trial_reg <= trial_next;
         end
         if (commit_nv || commit_ram) begin
            active_reg <= pending_reg;
         end else if (imm_commit) begin
            active_reg <= trial_next;
            pending_reg <= trial_next;
         end else if (defer_store) begin
            pending_reg[idx] <= REQ_DATA_I;
         end
         if (commit_nv) begin
            nv_reg <= pending_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // alarm, reference, answer and wear tracking

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         alarm_reg <= ALARM_NONE;
         reference_reg <= REF_RESET_VALUE;
      end else begin
         alarm_reg <= alarm_next;
         if (ref_write) begin
            reference_reg <= REQ_DATA_I;
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         msg_code_reg <= ERR_NONE;
         rsp_valid_reg <= 1'b0;
         rsp_error_reg <= 1'b0;
         rsp_code_reg <= ERR_NONE;
         rsp_data_reg <= 16'h0000;
      end else begin
         rsp_valid_reg <= answer;
         if (REQ_VALID_I) begin
            msg_code_reg <= code_now;
         end
         if (answer) begin
            rsp_error_reg <= (code_now != ERR_NONE);
            rsp_code_reg <= code_now;
            rsp_data_reg <= (rd && code_now == ERR_NONE) ? read_value :
                            16'h0000;
         end
      end
   end

   // saturating count only warns; the store itself is never blocked
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         nv_store_reg <= 1'b0;
         nv_count_reg <= '0;
         nv_wear_reg <= 1'b0;
      end else begin
         nv_store_reg <= commit_nv;
         if (commit_nv && !nv_wear_reg) begin
            nv_count_reg <= nv_count_reg + NV_COUNT_WIDTH'(1);
         end
         nv_wear_reg <= (nv_count_reg >= NV_COUNT_WIDTH'(NV_ENDURANCE_CYCLES));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   generate
      for (genvar g = 0; g < NUM_PARAMS; g++) begin : g_flat
         assign ACTIVE_PARAMS_O[16*g +: 16] = active_reg[g];
         assign NV_PARAMS_O[16*g +: 16] = nv_reg[g];
         assign pending_flat[16*g +: 16] = pending_reg[g];
      end
   endgenerate

   assign RSP_VALID_O = rsp_valid_reg;
   assign RSP_ERROR_O = rsp_error_reg;
   assign RSP_CODE_O = rsp_code_reg;
   assign RSP_DATA_O = rsp_data_reg;
   assign ALARM_CODE_O = alarm_reg;
   assign REFERENCE_O = reference_reg;
   assign NV_STORE_O = nv_store_reg;
   assign NV_WEAR_LIMIT_O = nv_wear_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks

   alarm_idle_zero_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (EXT_FAULT_I == '0 && !LINK_TX_ERROR_I && !FAN_SERVICE_DUE_I &&
       !CAPACITOR_SERVICE_DUE_I) |=> (ALARM_CODE_O == 16'h0000))
      else $error("alarm code not zero while idle");

   ext_fault_first_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      EXT_FAULT_I[0] |=> (ALARM_CODE_O == 16'h0009))
      else $error("first external fault code wrong");

   ext_fault_last_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (EXT_FAULT_I == 6'h20) |=> (ALARM_CODE_O == 16'h000e))
      else $error("last external fault code wrong");

   tx_error_code_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (EXT_FAULT_I == '0 && LINK_TX_ERROR_I) |=>
      (ALARM_CODE_O == 16'h0016 || ALARM_CODE_O == 16'h001d))
      else $error("transmission error code wrong");

   service_codes_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (EXT_FAULT_I == '0 && !LINK_TX_ERROR_I &&
       (FAN_SERVICE_DUE_I || CAPACITOR_SERVICE_DUE_I)) |=>
      (ALARM_CODE_O == ($past(FAN_SERVICE_DUE_I) ? 16'h0035 : 16'h0036)))
      else $error("service alarm code wrong");

   alarm_read_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (answer && rd && hit_alarm) |=>
      (RSP_VALID_O && !RSP_ERROR_O &&
       RSP_DATA_O == $past(ALARM_CODE_O)))
      else $error("alarm read returned wrong data");

   commit_nv_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      commit_nv |=> (NV_STORE_O && NV_PARAMS_O == $past(pending_flat) &&
                     ACTIVE_PARAMS_O == $past(pending_flat)))
      else $error("non-volatile commit incomplete");

   commit_ram_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      commit_ram |=> (!NV_STORE_O && $stable(NV_PARAMS_O) &&
                      ACTIVE_PARAMS_O == $past(pending_flat)))
      else $error("ram commit wrong");

   commit_read_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (answer && rd && (hit_nv || hit_ram)) |=>
      (RSP_ERROR_O && RSP_CODE_O == 8'h02))
      else $error("commit register read not refused");

   ref_apply_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      ref_write |=> (REFERENCE_O == $past(REQ_DATA_I)))
      else $error("reference not applied at once");

   deferred_hold_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (param_wr && !mode_imm) |=> $stable(ACTIVE_PARAMS_O))
      else $error("deferred write changed active set");

   deferred_drop_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (param_wr && !mode_imm && !in_limits && REQ_FIRST_I && REQ_LAST_I) |=>
      (!RSP_ERROR_O && $stable(pending_flat)))
      else $error("deferred invalid value not dropped silently");

   imm_apply_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (param_wr && mode_imm && param_ok && REQ_FIRST_I && REQ_LAST_I) |=>
      (active_reg[$past(idx)] == $past(REQ_DATA_I)))
      else $error("immediate write not applied");

   imm_reject_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (answer && wr && mode_imm && code_now != 8'h00) |=>
      (RSP_ERROR_O && $stable(ACTIVE_PARAMS_O)))
      else $error("immediate bad message not discarded");

   data_error_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (param_wr && mode_imm && !in_limits && REQ_FIRST_I && REQ_LAST_I) |=>
      (RSP_CODE_O == 8'h21))
      else $error("range error code wrong");

endmodule : parameter_commit_alarm_regs
